// *** hw/fault_log_and_overload_guard.sv ***
// Fault recorder and motor protection supervisor with Avalon-MM registers
//
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "fault_guard_defines.svh"
module fault_log_and_overload_guard (
  input wire logic REF_CLK_IN,
  input wire logic NRST_IN,
  input wire logic [4:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  input wire logic [7:0] TRIP_CAUSE_IN,
  input wire logic [1:0] RUN_STATE_IN,
  input wire logic RUNNING_IN,
  input wire logic ACCEL_IN,
  input wire logic DECEL_IN,
  input wire logic [15:0] OUT_FREQ_IN,
  input wire logic [15:0] OUT_CURRENT_IN,
  input wire logic [7:0] CURRENT_PCT_IN,
  input wire logic BUS_OVERVOLT_IN,
  input wire logic [7:0] SPEED_PCT_IN,
  input wire logic KEY_RESET_IN,
  input wire logic TERM_RESET_IN,
  output logic OUTPUT_BLOCK_OUT,
  output logic STALL_DECEL_OUT,
  output logic DECEL_HOLD_OUT,
  output logic RESTART_COUNT_CLEAR_OUT,
  output logic RELAY_OUT,
  output logic OVERLOAD_WARN_OUT
);
  localparam int TENTH_CYCLES = `TENTH_SEC_CYCLES;
  localparam logic [4:0] REG_OVERLOAD_WARN_FN = `RELAY_FN_OVERLOAD;

  logic thermal_model_enable;
  logic motor_cooling_style;
  logic [7:0] thermal_one_minute_level;
  logic [7:0] thermal_continuous_level;
  logic [7:0] overload_warning_level;
  logic [8:0] overload_warning_time;
  logic overload_trip_enable;
  logic [7:0] overload_trip_level;
  logic [9:0] overload_trip_time;
  logic [2:0] stall_prevention_select;
  logic [7:0] stall_current_level;
  logic [4:0] relay_function_select;
  logic auto_restart_enable;
  fault_guard_pkg::fault_rec_t active_fault_record;
  fault_guard_pkg::fault_rec_t history [`HIST_DEPTH];
  logic [7:0] prot_cause;
  logic tripped;
  logic [31:0] tick_count;
  logic tick;
  logic [8:0] warn_count;
  logic [9:0] trip_count;
  logic [16:0] heat;
  logic stall_active;
  logic wait_done;
  logic fault_reset;
  logic wr;
  logic [7:0] new_cause;
  fault_guard_pkg::ramp_t next_ramp;

  function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    if (v < lo) begin
      return lo;
    end
    if (v > hi) begin
      return hi;
    end
    return v;
  endfunction : clamp

  function automatic logic [31:0] pack_rec(input fault_guard_pkg::fault_rec_t r, input logic hi);
    if (hi) begin
      return {r.current, r.freq};
    end
    return {19'h0, r.valid, r.state, r.ramp, r.cause};
  endfunction : pack_rec

  // One wait state on every access
  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      wait_done <= 1'h0;
    end else begin
      wait_done <= (AVS_READ_IN || AVS_WRITE_IN) && !wait_done;
    end
  end
  assign AVS_WAITREQUEST_OUT = (AVS_READ_IN || AVS_WRITE_IN) && !wait_done;
  assign wr = AVS_WRITE_IN && wait_done;
  assign fault_reset = KEY_RESET_IN || TERM_RESET_IN;

  // Settings with range checks
  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      thermal_model_enable <= `RST_THERMAL_ENABLE;
      motor_cooling_style <= `RST_COOLING;
      thermal_one_minute_level <= `RST_ONE_MIN;
      thermal_continuous_level <= `RST_CONT;
      overload_warning_level <= `RST_WARN_LEVEL;
      overload_warning_time <= `RST_WARN_TIME;
      overload_trip_enable <= `RST_TRIP_ENABLE;
      overload_trip_level <= `RST_TRIP_LEVEL;
      overload_trip_time <= `RST_TRIP_TIME;
      stall_prevention_select <= `RST_STALL_SEL;
      stall_current_level <= `RST_STALL_LEVEL;
      relay_function_select <= `RST_RELAY_FN;
      auto_restart_enable <= 1'h0;
    end else if (wr) begin
      unique case (AVS_ADDRESS_IN)
        `ADDR_CTRL: begin
          relay_function_select <= AVS_WRITEDATA_IN[4:0];
          auto_restart_enable <= AVS_WRITEDATA_IN[8];
        end
        `ADDR_THERMAL: begin
          thermal_model_enable <= AVS_WRITEDATA_IN[0];
          if (thermal_model_enable) begin
            motor_cooling_style <= AVS_WRITEDATA_IN[1];
            if (AVS_WRITEDATA_IN[15:8] >= thermal_continuous_level && AVS_WRITEDATA_IN[15:8] <= `MAX_LEVEL) begin
              thermal_one_minute_level <= AVS_WRITEDATA_IN[15:8];
            end
            if (AVS_WRITEDATA_IN[23:16] >= `MIN_CONT && AVS_WRITEDATA_IN[23:16] < thermal_one_minute_level
                && AVS_WRITEDATA_IN[23:16] < `RST_ONE_MIN) begin
              thermal_continuous_level <= AVS_WRITEDATA_IN[23:16];
            end
          end
        end
        `ADDR_OVERLOAD: begin
          overload_warning_level <= clamp(AVS_WRITEDATA_IN[7:0], `MIN_LEVEL, `MAX_WARN_LEVEL);
          overload_warning_time <= (AVS_WRITEDATA_IN[16:8] > `MAX_WARN_TIME) ? `MAX_WARN_TIME
                                   : AVS_WRITEDATA_IN[16:8];
          overload_trip_enable <= AVS_WRITEDATA_IN[17];
          if (overload_trip_enable) begin
            overload_trip_level <= clamp(AVS_WRITEDATA_IN[25:18], `MIN_LEVEL, `MAX_LEVEL);
          end
        end
        `ADDR_STALL: begin
          stall_prevention_select <= AVS_WRITEDATA_IN[2:0];
          stall_current_level <= clamp(AVS_WRITEDATA_IN[15:8], `MIN_LEVEL, `MAX_LEVEL);
          if (overload_trip_enable) begin
            overload_trip_time <= (AVS_WRITEDATA_IN[25:16] > `MAX_TRIP_TIME) ? `MAX_TRIP_TIME
                                  : AVS_WRITEDATA_IN[25:16];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Tenth-second enable
  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      tick_count <= 32'h0;
    end else if (tick) begin
      tick_count <= 32'h0;
    end else begin
      tick_count <= tick_count + 32'h1;
    end
  end
  assign tick = (tick_count == 32'(TENTH_CYCLES - 1));

  // Overload warning timer
  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      warn_count <= 9'h0;
      OVERLOAD_WARN_OUT <= 1'h0;
    end else if (CURRENT_PCT_IN <= overload_warning_level) begin
      warn_count <= 9'h0;
      OVERLOAD_WARN_OUT <= 1'h0;
    end else begin
      if (tick && warn_count < overload_warning_time) begin
        warn_count <= warn_count + 9'h1;
      end
      OVERLOAD_WARN_OUT <= (warn_count >= overload_warning_time);
    end
  end

  // Thermal model: heat rises by excess over the continuous level
  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      heat <= 17'h0;
    end else if (!thermal_model_enable || fault_reset) begin
      heat <= 17'h0;
    end else if (tick) begin
      if (CURRENT_PCT_IN > thermal_continuous_level) begin
        heat <= heat + {9'h0, CURRENT_PCT_IN - thermal_continuous_level};
      end else if (heat != 17'h0) begin
        // Shaft fan does not cool at or below 50% speed
        heat <= (motor_cooling_style || SPEED_PCT_IN > 8'h32) ? heat - 17'h1 : heat;
      end
    end
  end

  // Overload trip timer
  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      trip_count <= 10'h0;
    end else if (!overload_trip_enable || CURRENT_PCT_IN <= overload_trip_level) begin
      trip_count <= 10'h0;
    end else if (tick && trip_count < overload_trip_time) begin
      trip_count <= trip_count + 10'h1;
    end
  end

  // Protection causes raised this cycle
  always_comb begin
    prot_cause = 8'h0;
    if (thermal_model_enable && {15'h0, heat} >=
        ({24'h0, thermal_one_minute_level} - {24'h0, thermal_continuous_level}) * 32'd600) begin
      prot_cause[1] = 1'h1;
    end
    if (overload_trip_enable && CURRENT_PCT_IN > overload_trip_level && trip_count >= overload_trip_time) begin
      prot_cause[2] = 1'h1;
    end
  end
  assign new_cause = TRIP_CAUSE_IN | prot_cause;

  always_comb begin
    next_ramp = fault_guard_pkg::RAMP_CONST;
    if (ACCEL_IN) begin
      next_ramp = fault_guard_pkg::RAMP_ACCEL;
    end else if (DECEL_IN) begin
      next_ramp = fault_guard_pkg::RAMP_DECEL;
    end
  end

  // Active trip capture; simultaneous causes share one record
  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      active_fault_record <= '0;
      tripped <= 1'h0;
      OUTPUT_BLOCK_OUT <= 1'h0;
      RESTART_COUNT_CLEAR_OUT <= 1'h0;
    end else begin
      RESTART_COUNT_CLEAR_OUT <= 1'h0;
      if (!tripped && RUNNING_IN && new_cause != 8'h0) begin
        tripped <= 1'h1;
        OUTPUT_BLOCK_OUT <= 1'h1;
        active_fault_record.valid <= 1'h1;
        active_fault_record.cause <= new_cause;
        active_fault_record.state <= RUN_STATE_IN;
        active_fault_record.freq <= OUT_FREQ_IN;
        active_fault_record.current <= OUT_CURRENT_IN;
        active_fault_record.ramp <= next_ramp;
        RESTART_COUNT_CLEAR_OUT <= prot_cause[2] && auto_restart_enable
                                   && overload_trip_time > `RESTART_TIME_LIMIT;
      end else if (tripped && fault_reset) begin
        tripped <= 1'h0;
        OUTPUT_BLOCK_OUT <= 1'h0;
        active_fault_record <= '0;
      end
    end
  end

  // History shift on reset, clear erases all
  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      for (int i = 0; i < `HIST_DEPTH; i++) begin
        history[i] <= '0;
      end
    end else if (wr && AVS_ADDRESS_IN == `ADDR_CTRL && AVS_WRITEDATA_IN[16]) begin
      for (int i = 0; i < `HIST_DEPTH; i++) begin
        history[i] <= '0;
      end
    end else if (tripped && fault_reset) begin
      history[0] <= active_fault_record;
      for (int i = 1; i < `HIST_DEPTH; i++) begin
        history[i] <= history[i-1];
      end
    end
  end

  // Stall prevention
  always_comb begin
    stall_active = CURRENT_PCT_IN > stall_current_level;
  end
  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      STALL_DECEL_OUT <= 1'h0;
      DECEL_HOLD_OUT <= 1'h0;
      RELAY_OUT <= 1'h0;
    end else begin
      // Ramp generator applies ramp times to these requests
      STALL_DECEL_OUT <= stall_active && !DECEL_IN &&
                         ((ACCEL_IN && stall_prevention_select[`STALL_BIT_ACCEL]) ||
                          (!ACCEL_IN && stall_prevention_select[`STALL_BIT_CONST]));
      DECEL_HOLD_OUT <= DECEL_IN && BUS_OVERVOLT_IN && stall_prevention_select[`STALL_BIT_DECEL];
      unique case (relay_function_select)
        REG_OVERLOAD_WARN_FN: RELAY_OUT <= OVERLOAD_WARN_OUT;
        `RELAY_FN_STALL: RELAY_OUT <= stall_active || (DECEL_IN && BUS_OVERVOLT_IN);
        default: RELAY_OUT <= tripped;
      endcase
    end
  end

  // Read data
  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      AVS_READDATA_OUT <= 32'h0;
    end else if (AVS_READ_IN && !wait_done) begin
      AVS_READDATA_OUT <= 32'h0;
      if (AVS_ADDRESS_IN >= `ADDR_HIST0) begin
        if ((AVS_ADDRESS_IN - `ADDR_HIST0) < 5'(2 * `HIST_DEPTH)) begin
          AVS_READDATA_OUT <= pack_rec(history[3'((AVS_ADDRESS_IN - `ADDR_HIST0) >> 1)], AVS_ADDRESS_IN[0]);
        end
      end else begin
        unique case (AVS_ADDRESS_IN)
          `ADDR_CTRL: AVS_READDATA_OUT <= {23'h0, auto_restart_enable, 3'h0, relay_function_select};
          `ADDR_THERMAL: AVS_READDATA_OUT <= thermal_model_enable ?
            {8'h0, thermal_continuous_level, thermal_one_minute_level, 6'h0, motor_cooling_style, 1'h1}
            : 32'h0;
          `ADDR_OVERLOAD: AVS_READDATA_OUT <= {6'h0, overload_trip_enable ? overload_trip_level : 8'h0,
            overload_trip_enable, overload_warning_time, overload_warning_level};
          `ADDR_STALL: AVS_READDATA_OUT <= {6'h0, overload_trip_enable ? overload_trip_time : 10'h0,
            stall_current_level, 5'h0, stall_prevention_select};
          `ADDR_STATUS: AVS_READDATA_OUT <= {27'h0, STALL_DECEL_OUT, DECEL_HOLD_OUT, RELAY_OUT,
            OVERLOAD_WARN_OUT, tripped};
          `ADDR_ACTIVE: AVS_READDATA_OUT <= pack_rec(active_fault_record, 1'h0);
          5'h06: AVS_READDATA_OUT <= pack_rec(active_fault_record, 1'h1);
          default: AVS_READDATA_OUT <= 32'h0;
        endcase
      end
    end
  end

  // Protection, history and bus wait checks
  property p_trip_blocks;
    @(posedge REF_CLK_IN) disable iff (!NRST_IN) (!tripped && RUNNING_IN && new_cause != 8'h0) |=> OUTPUT_BLOCK_OUT;
  endproperty
  a_trip_blocks: assert property (p_trip_blocks) else $error("trip did not block output");
  property p_block_stands;
    @(posedge REF_CLK_IN) disable iff (!NRST_IN) (tripped && !fault_reset) |=> OUTPUT_BLOCK_OUT;
  endproperty
  a_block_stands: assert property (p_block_stands) else $error("output block dropped while tripped");
  property p_hist_clear;
    @(posedge REF_CLK_IN) disable iff (!NRST_IN) (wr && AVS_ADDRESS_IN == `ADDR_CTRL && AVS_WRITEDATA_IN[16])
      |=> (history[0] == '0 && history[4] == '0);
  endproperty
  a_hist_clear: assert property (p_hist_clear) else $error("history not cleared");
  property p_hist_shift;
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
      (tripped && fault_reset && !(wr && AVS_ADDRESS_IN == `ADDR_CTRL && AVS_WRITEDATA_IN[16]))
      |=> (history[0] == $past(active_fault_record) && history[1] == $past(history[0]));
  endproperty
  a_hist_shift: assert property (p_hist_shift) else $error("history did not shift");
  property p_decel_hold;
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
      (DECEL_IN && BUS_OVERVOLT_IN && stall_prevention_select[`STALL_BIT_DECEL]) |=> DECEL_HOLD_OUT;
  endproperty
  a_decel_hold: assert property (p_decel_hold) else $error("deceleration not paused");
  property p_warn_release;
    @(posedge REF_CLK_IN) disable iff (!NRST_IN) (CURRENT_PCT_IN <= overload_warning_level) |=> !OVERLOAD_WARN_OUT;
  endproperty
  a_warn_release: assert property (p_warn_release) else $error("warning held below level");
  property p_one_wait;
    @(posedge REF_CLK_IN) disable iff (!NRST_IN) AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("more than one wait state");
endmodule : fault_log_and_overload_guard
`default_nettype wire

// *** hw/fault_guard_defines.svh ***
// Register offsets, field positions, reset values and timing counts for the fault guard
`ifndef FAULT_GUARD_DEFINES_SVH
`define FAULT_GUARD_DEFINES_SVH
`define ADDR_CTRL 5'h00
`define ADDR_THERMAL 5'h01
`define ADDR_OVERLOAD 5'h02
`define ADDR_STALL 5'h03
`define ADDR_STATUS 5'h04
`define ADDR_ACTIVE 5'h05
`define ADDR_HIST0 5'h08
`define HIST_DEPTH 5
`define RST_THERMAL_ENABLE 1'h0
`define RST_COOLING 1'h0
`define RST_ONE_MIN 8'h96
`define RST_CONT 8'h64
`define RST_WARN_LEVEL 8'h96
`define RST_WARN_TIME 9'h064
`define RST_TRIP_ENABLE 1'h1
`define RST_TRIP_LEVEL 8'hB4
`define RST_TRIP_TIME 10'h258
`define RST_STALL_SEL 3'h0
`define RST_STALL_LEVEL 8'h96
`define RST_RELAY_FN 5'h11
`define MIN_LEVEL 8'h1E
`define MAX_LEVEL 8'hC8
`define MAX_WARN_LEVEL 8'h96
`define MIN_CONT 8'h32
`define MAX_WARN_TIME 9'h12C
`define MAX_TRIP_TIME 10'h258
`define RESTART_TIME_LIMIT 10'h12C
`define RELAY_FN_OVERLOAD 5'h05
`define RELAY_FN_STALL 5'h07
`define CLK_HZ 250000000
`define TENTH_SEC_MS 100
`define TENTH_SEC_CYCLES ((`CLK_HZ / 1000) * `TENTH_SEC_MS)
`define STALL_BIT_ACCEL 0
`define STALL_BIT_CONST 1
`define STALL_BIT_DECEL 2
`endif

// *** hw/fault_guard_pkg.sv ***
// Types shared by the fault guard
package fault_guard_pkg;
  typedef enum logic [1:0] {RAMP_ACCEL, RAMP_DECEL, RAMP_CONST} ramp_t;
  typedef struct packed {
    logic valid;
    logic [7:0] cause;
    logic [1:0] ramp;
    logic [1:0] state;
    logic [15:0] freq;
    logic [15:0] current;
  } fault_rec_t;
endpackage : fault_guard_pkg

// *** tb/drive_stage_model.sv ***
// Behavioural drive stage, keypad and input terminal facing the fault guard
`timescale 1ns/100ps
`default_nettype none
module drive_stage_model (
  input wire logic clk_in,
  input wire logic [1:0] phase_in,
  input wire logic [7:0] pct_in,
  input wire logic [7:0] cause_in,
  input wire logic ovv_in,
  input wire logic [1:0] rst_in,
  output logic running_out,
  output logic accel_out,
  output logic decel_out,
  output logic [7:0] cause_out,
  output logic [7:0] pct_out,
  output logic ovv_out,
  output logic key_rst_out,
  output logic term_rst_out
);
  initial begin
    {running_out, accel_out, decel_out, cause_out, pct_out, ovv_out, key_rst_out, term_rst_out} = '0;
  end
  // Stage state changes just after each clock edge
  always @(posedge clk_in) begin
    running_out <= 1'b1;
    accel_out <= (phase_in == 2'h0);
    decel_out <= (phase_in == 2'h1);
    cause_out <= cause_in;
    pct_out <= pct_in;
    ovv_out <= ovv_in;
    key_rst_out <= rst_in[0];
    term_rst_out <= rst_in[1];
  end
endmodule : drive_stage_model
`default_nettype wire

// *** tb/fault_log_and_overload_guard_test.sv ***
// Self-checking bench for the fault recorder and protection supervisor
`timescale 1ns/100ps
`default_nettype none
module fault_log_and_overload_guard_test;
  typedef struct packed {logic [2:0] sel; logic [1:0] ph; logic [7:0] pct; logic ov; logic sd; logic hold; logic rly;} row_t;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic wait_out;
  logic [1:0] ph = 2'h2;
  logic [7:0] pct = 8'h40;
  logic [7:0] cause = '0;
  logic ov = 1'b0;
  logic [1:0] rstq = '0;
  logic [15:0] frq = '0;
  logic [15:0] cur = '0;
  logic running, accel, decel, ovv_m, key_r, term_r;
  logic [7:0] cause_m, pct_m;
  logic block, sdec, hold, rcc, relay, warn;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  int n_rc = 0;
  logic [31:0] q;
  row_t rows [8] = '{'{3'h1, 2'h0, 8'h97, 1'b0, 1'b1, 1'b0, 1'b1}, '{3'h1, 2'h0, 8'h96, 1'b0, 1'b0, 1'b0, 1'b0},
    '{3'h2, 2'h0, 8'hC8, 1'b0, 1'b0, 1'b0, 1'b1}, '{3'h2, 2'h2, 8'h97, 1'b0, 1'b1, 1'b0, 1'b1},
    '{3'h4, 2'h1, 8'h50, 1'b1, 1'b0, 1'b1, 1'b1}, '{3'h3, 2'h1, 8'h50, 1'b1, 1'b0, 1'b0, 1'b1},
    '{3'h4, 2'h1, 8'h50, 1'b0, 1'b0, 1'b0, 1'b0}, '{3'h7, 2'h2, 8'hA0, 1'b0, 1'b1, 1'b0, 1'b1}};

  drive_stage_model stage (.clk_in(clk), .phase_in(ph), .pct_in(pct), .cause_in(cause), .ovv_in(ov),
    .rst_in(rstq), .running_out(running), .accel_out(accel), .decel_out(decel), .cause_out(cause_m),
    .pct_out(pct_m), .ovv_out(ovv_m), .key_rst_out(key_r), .term_rst_out(term_r));

  fault_log_and_overload_guard dut (.REF_CLK_IN(clk), .NRST_IN(nrst), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_out),
    .TRIP_CAUSE_IN(cause_m), .RUN_STATE_IN(2'h1), .RUNNING_IN(running), .ACCEL_IN(accel), .DECEL_IN(decel),
    .OUT_FREQ_IN(frq), .OUT_CURRENT_IN(cur), .CURRENT_PCT_IN(pct_m), .BUS_OVERVOLT_IN(ovv_m),
    .SPEED_PCT_IN(8'h50), .KEY_RESET_IN(key_r), .TERM_RESET_IN(term_r), .OUTPUT_BLOCK_OUT(block),
    .STALL_DECEL_OUT(sdec), .DECEL_HOLD_OUT(hold), .RESTART_COUNT_CLEAR_OUT(rcc), .RELAY_OUT(relay),
    .OVERLOAD_WARN_OUT(warn));

  always #2 clk = ~clk;

  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  always @(posedge clk) begin
    cycles++;
    if (rcc === 1'b1) n_rc++;
    if (cycles == LIMIT) begin
      failures++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask : chkb

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
    end while (wait_out !== 1'b0);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr_reg

  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, '0, r);
    chk($sformatf("reg%0h", a), e, r);
  endtask : rdc

  function automatic logic [31:0] lw(input int k);
    return 32'(32'h1400 | ((k % 3) << 8) | ((k + 1) * 8));
  endfunction : lw

  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chkb("block", 1'b0, block);
    rdc(4'h0, 32'h11);
    rdc(4'h2, 32'h02D26496);
    rdc(4'h3, 32'h02589600);
    rdc(4'h7, 32'h0);
    wr_reg(4'h0, 32'h7);
    foreach (rows[i]) begin
      wr_reg(4'h3, {6'h0, 10'h258, 8'h96, 5'h0, rows[i].sel});
      ph <= rows[i].ph;
      pct <= rows[i].pct;
      ov <= rows[i].ov;
      repeat (4) @(posedge clk);
      chkb("stall_decel", rows[i].sd, sdec);
      chkb("decel_hold", rows[i].hold, hold);
      chkb("relay", rows[i].rly, relay);
    end
    pct <= 8'h40;
    ov <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      ph <= 2'(i % 3);
      cause <= 8'((i + 1) * 8);
      frq <= 16'h0100 + 16'(i);
      cur <= 16'h0200 + 16'(i);
      repeat (4) @(posedge clk);
      chkb("block", 1'b1, block);
      if (i == 0) begin
        rdc(4'h5, lw(0));
        rdc(4'h6, 32'h02000100);
      end
      cause <= '0;
      rstq <= i[0] ? 2'h2 : 2'h1;
      @(posedge clk);
      rstq <= '0;
      repeat (3) @(posedge clk);
      chkb("block", 1'b0, block);
    end
    for (int n = 0; n < 5; n++) begin
      rdc(5'(8 + 2 * n), lw(5 - n));
      rdc(5'(9 + 2 * n), {16'h0200 + 16'(5 - n), 16'h0100 + 16'(5 - n)});
    end
    wr_reg(4'h0, 32'h00010007);
    for (int n = 0; n < 10; n++) begin
      rdc(5'(8 + n), 32'h0);
    end
    wr_reg(4'h3, 32'h00009600);
    wr_reg(4'h2, 32'h03220064);
    wr_reg(4'h0, 32'h105);
    pct <= 8'h65;
    repeat (4) @(posedge clk);
    chkb("warn", 1'b1, warn);
    chkb("relay", 1'b1, relay);
    pct <= 8'h64;
    repeat (4) @(posedge clk);
    chkb("warn", 1'b0, warn);
    chkb("relay", 1'b0, relay);
    pct <= 8'hC9;
    repeat (4) @(posedge clk);
    chkb("block", 1'b1, block);
    bus(1'b0, 4'h5, '0, q);
    chkb("overload_cause", 1'b1, q[2]);
    chk("restart_clears", 32'h0, 32'(n_rc));
    rstq <= 2'h1;
    pct <= 8'h40;
    @(posedge clk);
    rstq <= '0;
    repeat (3) @(posedge clk);
    chkb("block", 1'b0, block);
    wr_reg(4'h2, 32'h004390FF);
    rdc(4'h2, 32'h007B2C96);
    rdc(4'h1, 32'h0);
    wr_reg(4'h1, 32'h00786403);
    rdc(4'h1, 32'h00649601);
    wr_reg(4'h1, 32'h0096C801);
    rdc(4'h1, 32'h0064C801);
    wr_reg(4'h1, 32'h0078C803);
    rdc(4'h1, 32'h0078C803);
    wr_reg(4'h1, 32'h0031C803);
    rdc(4'h1, 32'h0078C803);
    close_out();
  end
endmodule : fault_log_and_overload_guard_test
`default_nettype wire
